// ### hw/pjb_dev_end.sv
// Purpose: Device end: TAP controller, user port and PLL config register
// Assumes: tck, tms, tdi arrive from pins and are synchronised to clk
// Notes: Test clock must stay well below a quarter of the clk rate
`timescale 1ns/1ns
module pjb_dev_end (
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic [pjb_pkg::CFG_W-1:0] pll_ctrl_bits,
   pjb_link_if.dev lnk
);
   import pjb_pkg::*;

   // Pin synchronisers, first stage read only by the second
   logic tck_s1_ff;
   logic tck_s2_ff;
   logic tck_d_ff;
   logic tms_s1_ff;
   logic tms_s2_ff;
   logic tdi_s1_ff;
   logic tdi_s2_ff;
   logic nxt_tck_s1;
   logic nxt_tck_s2;
   logic nxt_tck_d;
   logic nxt_tms_s1;
   logic nxt_tms_s2;
   logic nxt_tdi_s1;
   logic nxt_tdi_s2;
   logic tck_rise;
   logic tck_fall;

   // TAP state and data paths
   pjb_tap_e state_ff;
   pjb_tap_e nxt_state;
   logic [IR_W-1:0] ir_sr_ff;
   logic [IR_W-1:0] ir_ff;
   logic byp_ff;
   logic tdo_ff;
   logic tdo_oe_ff;
   logic [IR_W-1:0] nxt_ir_sr;
   logic [IR_W-1:0] nxt_ir;
   logic nxt_byp;
   logic nxt_tdo;
   logic nxt_tdo_oe;

   // Standard TAP transitions on one test clock rise
   function automatic pjb_tap_e tap_next(input pjb_tap_e s,
                                         input logic m);
      begin
         case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
         endcase
      end
   endfunction

   // Two flops on every pin, then one more on tck for edge finding
   always_comb begin
      nxt_tck_s1 = tck;
      nxt_tck_s2 = tck_s1_ff;
      nxt_tck_d = tck_s2_ff;
      nxt_tms_s1 = tms;
      nxt_tms_s2 = tms_s1_ff;
      nxt_tdi_s1 = tdi;
      nxt_tdi_s2 = tdi_s1_ff;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tck_s1_ff <= 1'b0;
         tck_s2_ff <= 1'b0;
         tck_d_ff <= 1'b0;
         tms_s1_ff <= 1'b1;
         tms_s2_ff <= 1'b1;
         tdi_s1_ff <= 1'b0;
         tdi_s2_ff <= 1'b0;
      end else begin
         tck_s1_ff <= nxt_tck_s1;
         tck_s2_ff <= nxt_tck_s2;
         tck_d_ff <= nxt_tck_d;
         tms_s1_ff <= nxt_tms_s1;
         tms_s2_ff <= nxt_tms_s2;
         tdi_s1_ff <= nxt_tdi_s1;
         tdi_s2_ff <= nxt_tdi_s2;
      end
   end

   // tms and tdi share the tck latency, so they line up with the edge
   assign tck_rise = tck_s2_ff & ~tck_d_ff;
   assign tck_fall = ~tck_s2_ff & tck_d_ff;

   // State walk, instruction path and bypass bit
   always_comb begin
      nxt_state = state_ff;
      nxt_ir_sr = ir_sr_ff;
      nxt_ir = ir_ff;
      nxt_byp = byp_ff;
      if (tck_rise) begin
         nxt_state = tap_next(state_ff, tms_s2_ff);
         case (state_ff)
            TAP_RESET: begin
               nxt_ir = IR_RESET_VAL;
            end
            TAP_CAP_IR: begin
               nxt_ir_sr = IR_CAPTURE_VAL;
            end
            TAP_SHIFT_IR: begin
               nxt_ir_sr = {tdi_s2_ff, ir_sr_ff[IR_W-1:1]};
            end
            TAP_UPD_IR: begin
               nxt_ir = ir_sr_ff;
            end
            TAP_CAP_DR: begin
               nxt_byp = 1'b0;
            end
            TAP_SHIFT_DR: begin
               nxt_byp = tdi_s2_ff;
            end
            default: begin
               nxt_byp = byp_ff;
            end
         endcase
      end
   end

   // Power-up lands in Test-Logic-Reset and waits for pin activity
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= TAP_RESET;
         ir_sr_ff <= IR_RESET_VAL;
         ir_ff <= IR_RESET_VAL;
         byp_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ir_sr_ff <= nxt_ir_sr;
         ir_ff <= nxt_ir;
         byp_ff <= nxt_byp;
      end
   end

   // TDO changes on the falling test clock, as the TAP expects
   always_comb begin
      nxt_tdo = tdo_ff;
      nxt_tdo_oe = tdo_oe_ff;
      if (tck_fall) begin
         nxt_tdo_oe = 1'b0;
         nxt_tdo = 1'b0;
         if (state_ff == TAP_SHIFT_DR) begin
            nxt_tdo_oe = 1'b1;
            // Outside the user range the bypass bit answers instead
            nxt_tdo = pjb_user_range(ir_ff) ? lnk.user_serial_out
                                            : byp_ff;
         end else if (state_ff == TAP_SHIFT_IR) begin
            nxt_tdo_oe = 1'b1;
            nxt_tdo = ir_sr_ff[0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_ff <= nxt_tdo;
         tdo_oe_ff <= nxt_tdo_oe;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe = tdo_oe_ff;

   // User port, strobes decoded straight from the state register
   assign lnk.instr_reg_bus = ir_ff;
   assign lnk.user_serial_in = tdi_s2_ff;
   assign lnk.test_clock_out = tck_s2_ff;
   assign lnk.dr_shift_strobe = (state_ff == TAP_SHIFT_DR);
   assign lnk.dr_update_strobe = (state_ff == TAP_UPD_DR);
   assign lnk.dr_capture_strobe = (state_ff == TAP_CAP_DR);
   assign lnk.tap_reset_n = (state_ff != TAP_RESET);

   // PLL configuration register, fed only through the bridge
   pjb_pll_cfg pjb_pll_cfg_i (
      .clk(clk),
      .rst(rst),
      .cfg_clk(lnk.pll_cfg_clk),
      .cfg_serial_in(lnk.pll_cfg_serial_in),
      .cfg_shift_en(lnk.pll_cfg_shift_en),
      .cfg_update(lnk.pll_cfg_update),
      .mode(lnk.pll_mode),
      .cfg_serial_out(lnk.pll_cfg_serial_out),
      .ctrl_bits(pll_ctrl_bits)
   );
endmodule

// ### hw/pjb_pkg.sv
// Purpose: Shared constants and types for the TAP to PLL config bridge
// Assumes: One system clock; test clock is sampled, not used as a clock
// Notes: Opcodes are the reference pair; other user codes reach only the one-bit stage
package pjb_pkg;
   // Instruction register geometry and user code range
   localparam int IR_W = 8;
   localparam logic [7:0] IR_USER_LO = 8'h10;
   localparam logic [7:0] IR_USER_HI = 8'h7F;
   // Reference opcodes of the bridge
   localparam logic [7:0] OPC_LOAD_CFG = 8'h20;
   localparam logic [7:0] OPC_DYNAMIC = 8'h21;
   // Values loaded into the instruction path
   localparam logic [7:0] IR_RESET_VAL = 8'hFF;
   localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;
   // PLL configuration register
   localparam int CFG_W = 27;
   localparam logic [26:0] PLL_STATIC_CFG = 27'h0000000;
   // Reset values of single-bit state
   localparam logic MODE_RESET = 1'b0;
   localparam logic STAGE_RESET = 1'b0;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
      TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
      TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } pjb_tap_e;

   // True when an instruction lies in the user range
   function automatic logic pjb_user_range(input logic [7:0] ir);
      pjb_user_range = (ir >= IR_USER_LO) && (ir <= IR_USER_HI);
   endfunction
endpackage

// ### hw/pjb_link_if.sv
// Purpose: Signals between the TAP user port and the bridge logic
// Assumes: Both ends run on the same system clock
// Notes: The test clock travels as a plain level sampled by both ends
`timescale 1ns/1ns
interface pjb_link_if;
   logic [7:0] instr_reg_bus;
   logic user_serial_in;
   logic user_serial_out;
   logic dr_shift_strobe;
   logic dr_update_strobe;
   logic dr_capture_strobe;
   logic tap_reset_n;
   logic test_clock_out;
   logic pll_cfg_serial_in;
   logic pll_cfg_serial_out;
   logic pll_cfg_shift_en;
   logic pll_cfg_update;
   logic pll_cfg_clk;
   logic pll_mode;

   modport dev (
      output instr_reg_bus, user_serial_in, dr_shift_strobe,
      output dr_update_strobe, dr_capture_strobe, tap_reset_n,
      output test_clock_out, pll_cfg_serial_out,
      input user_serial_out, pll_cfg_serial_in, pll_cfg_shift_en,
      input pll_cfg_update, pll_cfg_clk, pll_mode
   );
   modport brg (
      input instr_reg_bus, user_serial_in, dr_shift_strobe,
      input dr_update_strobe, dr_capture_strobe, tap_reset_n,
      input test_clock_out, pll_cfg_serial_out,
      output user_serial_out, pll_cfg_serial_in, pll_cfg_shift_en,
      output pll_cfg_update, pll_cfg_clk, pll_mode
   );
endinterface

// ### hw/pjb_pll_cfg.sv
// Purpose: PLL configuration shift register, update latch and mode mux
// Assumes: cfg_clk is a level from logic on clk, edges found here
// Notes: Shift happens on the cycle that sees a cfg_clk rising edge
`timescale 1ns/1ns
module pjb_pll_cfg (
   input wire logic clk,
   input wire logic rst,
   input wire logic cfg_clk,
   input wire logic cfg_serial_in,
   input wire logic cfg_shift_en,
   input wire logic cfg_update,
   input wire logic mode,
   output logic cfg_serial_out,
   output logic [pjb_pkg::CFG_W-1:0] ctrl_bits
);
   import pjb_pkg::*;

   logic cfg_clk_d_ff;
   logic [CFG_W-1:0] sreg_ff;
   logic [CFG_W-1:0] latch_ff;
   logic [CFG_W-1:0] ctrl_ff;
   logic nxt_cfg_clk_d;
   logic [CFG_W-1:0] nxt_sreg;
   logic [CFG_W-1:0] nxt_latch;
   logic [CFG_W-1:0] nxt_ctrl;
   logic cfg_rise;

   assign cfg_rise = cfg_clk & ~cfg_clk_d_ff;

   // Shift LSB first, latch on update, select source by mode
   always_comb begin
      nxt_cfg_clk_d = cfg_clk;
      nxt_sreg = sreg_ff;
      nxt_latch = latch_ff;
      if (cfg_rise && cfg_shift_en) begin
         nxt_sreg = {cfg_serial_in, sreg_ff[CFG_W-1:1]};
      end
      // Latch holds while shifting, so the PLL never sees partial words
      if (cfg_update) begin
         nxt_latch = sreg_ff;
      end
      nxt_ctrl = mode ? latch_ff : PLL_STATIC_CFG;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_clk_d_ff <= 1'b0;
         sreg_ff <= '0;
         latch_ff <= '0;
         ctrl_ff <= PLL_STATIC_CFG;
      end else begin
         cfg_clk_d_ff <= nxt_cfg_clk_d;
         sreg_ff <= nxt_sreg;
         latch_ff <= nxt_latch;
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign cfg_serial_out = sreg_ff[0];
   assign ctrl_bits = ctrl_ff;
endmodule

// ### hw/pjb_bridge_end.sv
// Purpose: User interface block between the TAP user port and the PLL
// Assumes: test_clock_out is a level from logic on clk, no sync needed
// Notes: Only the reference opcodes are decoded; others get the one-bit stage with capture 0
`timescale 1ns/1ns
module pjb_bridge_end (
   input wire logic clk,
   input wire logic rst,
   output logic mode_status,
   output logic load_selected,
   pjb_link_if.brg lnk
);
   import pjb_pkg::*;

   logic tck_d_ff;
   logic stage_ff;
   logic mode_ff;
   logic nxt_tck_d;
   logic nxt_stage;
   logic nxt_mode;
   logic tck_rise;
   logic hit_load;
   logic hit_dyn;

   // Opcode compare, used for both reference codes
   function automatic logic op_match(input logic [7:0] ir,
                                     input logic [7:0] op);
      op_match = (ir == op);
   endfunction

   // Decoded every cycle, never sampled, so no stale match
   assign hit_load = op_match(lnk.instr_reg_bus, OPC_LOAD_CFG);
   assign hit_dyn = op_match(lnk.instr_reg_bus, OPC_DYNAMIC);
   assign tck_rise = lnk.test_clock_out & ~tck_d_ff;

   // Gated PLL update and shift, direct data and clock; strobes come from distinct states
   assign lnk.pll_cfg_update = lnk.dr_update_strobe & hit_load;
   assign lnk.pll_cfg_shift_en = lnk.dr_shift_strobe & hit_load;
   assign lnk.pll_cfg_serial_in = lnk.user_serial_in;
   assign lnk.pll_cfg_clk = lnk.test_clock_out;

   // Return line selection
   assign lnk.user_serial_out = hit_load ? lnk.pll_cfg_serial_out
                                         : stage_ff;

   // One-bit stage moves on test clock rises; mode follows update
   always_comb begin
      nxt_tck_d = lnk.test_clock_out;
      nxt_stage = stage_ff;
      nxt_mode = mode_ff;
      if (tck_rise) begin
         if (lnk.dr_capture_strobe) begin
            nxt_stage = hit_dyn ? mode_ff : STAGE_RESET;
         end else if (lnk.dr_shift_strobe) begin
            nxt_stage = lnk.user_serial_in;
         end
      end
      // Reset beats update, mirroring a cleared latch
      if (!lnk.tap_reset_n) begin
         nxt_mode = MODE_RESET;
      end else if (lnk.dr_update_strobe && hit_dyn) begin
         nxt_mode = stage_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tck_d_ff <= 1'b0;
         stage_ff <= STAGE_RESET;
         mode_ff <= MODE_RESET;
      end else begin
         tck_d_ff <= nxt_tck_d;
         stage_ff <= nxt_stage;
         mode_ff <= nxt_mode;
      end
   end

   assign lnk.pll_mode = mode_ff;
   assign mode_status = mode_ff;
   assign load_selected = hit_load;
endmodule

// ### test/pjb_bridge_checker.sv
// Purpose: Concurrent checks on the link between TAP end and bridge
// Assumes: All link signals are levels on clk
// Notes: Instantiated beside the link interface, not bound
`timescale 1ns/1ns
module pjb_bridge_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] instr_reg_bus,
   input wire logic user_serial_in,
   input wire logic user_serial_out,
   input wire logic dr_shift_strobe,
   input wire logic dr_update_strobe,
   input wire logic dr_capture_strobe,
   input wire logic tap_reset_n,
   input wire logic test_clock_out,
   input wire logic pll_cfg_serial_in,
   input wire logic pll_cfg_serial_out,
   input wire logic pll_cfg_shift_en,
   input wire logic pll_cfg_update,
   input wire logic pll_cfg_clk,
   input wire logic pll_mode
);
   import pjb_pkg::*;
   logic mode_load;
   // Only an update under the mode opcode, or TAP reset, may move the mode
   assign mode_load = dr_update_strobe && instr_reg_bus == OPC_DYNAMIC;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Config shifting in progress
   sequence s_cfg_shift;
      pll_cfg_shift_en;
   endsequence
   // TAP leaves its reset state
   sequence s_tap_leaves_reset;
      $rose(tap_reset_n);
   endsequence
   chk_update_gate: assert property (
      pll_cfg_update == (dr_update_strobe && instr_reg_bus == OPC_LOAD_CFG))
      else $error("PLL update not gated by load opcode");
   chk_shift_gate: assert property (
      pll_cfg_shift_en == (dr_shift_strobe && instr_reg_bus == OPC_LOAD_CFG))
      else $error("PLL shift not gated by load opcode");
   chk_no_upd_shift: assert property (s_cfg_shift |-> !pll_cfg_update)
      else $error("PLL update high while shifting");
   chk_return_line: assert property (
      instr_reg_bus == OPC_LOAD_CFG |-> user_serial_out == pll_cfg_serial_out)
      else $error("return line not PLL output under load opcode");
   chk_direct_route: assert property (
      pll_cfg_serial_in == user_serial_in && pll_cfg_clk == test_clock_out)
      else $error("PLL data or clock not routed directly");
   chk_mode_clear: assert property (!tap_reset_n |=> !pll_mode)
      else $error("mode not cleared by TAP reset");
   chk_mode_cause: assert property (
      $changed(pll_mode) |-> $past(mode_load) || !tap_reset_n)
      else $error("mode changed without update under mode opcode");
   chk_ir_steady: assert property ($changed(instr_reg_bus) |->
      !dr_shift_strobe && !dr_update_strobe && !dr_capture_strobe)
      else $error("instruction changed inside a DR state");
   chk_reset_exit: assert property (s_tap_leaves_reset |-> test_clock_out)
      else $error("TAP left reset without a test clock rise");
   chk_shift_tck: assert property (
      $changed(dr_shift_strobe) |-> test_clock_out)
      else $error("shift strobe moved away from a test clock rise");
   chk_strobe_excl: assert property (
      $onehot0({dr_capture_strobe, dr_shift_strobe, dr_update_strobe}))
      else $error("more than one DR strobe high");
   chk_reset_quiet: assert property (!tap_reset_n |->
      !dr_shift_strobe && !dr_update_strobe && !dr_capture_strobe)
      else $error("DR strobe high in TAP reset");
endmodule

// ### test/jtag_pll_config_bridge_test.sv
// Purpose: Drives JTAG pins of the device end, checks both ends
// Assumes: Test clock period 320 ns, 4 clk low and 4 clk high
// Notes: Pins change only at falling clk edges
`timescale 1ns/1ns
module jtag_pll_config_bridge_test;
   import pjb_pkg::*;
   logic clk, rst, tck, tms, tdi, tdo, tdo_oe, mode_status, load_selected;
   logic [CFG_W-1:0] pll_ctrl_bits;
   logic [26:0] sr_exp, latch_exp, word, got;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   pjb_link_if lnk_i();
   pjb_dev_end pjb_dev_end_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .pll_ctrl_bits(pll_ctrl_bits), .lnk(lnk_i));
   pjb_bridge_end pjb_bridge_end_i (.clk(clk), .rst(rst),
      .mode_status(mode_status), .load_selected(load_selected), .lnk(lnk_i));
   pjb_bridge_checker pjb_bridge_checker_i (.clk(clk), .rst(rst),
      .instr_reg_bus(lnk_i.instr_reg_bus),
      .user_serial_in(lnk_i.user_serial_in),
      .user_serial_out(lnk_i.user_serial_out),
      .dr_shift_strobe(lnk_i.dr_shift_strobe),
      .dr_update_strobe(lnk_i.dr_update_strobe),
      .dr_capture_strobe(lnk_i.dr_capture_strobe),
      .tap_reset_n(lnk_i.tap_reset_n), .test_clock_out(lnk_i.test_clock_out),
      .pll_cfg_serial_in(lnk_i.pll_cfg_serial_in),
      .pll_cfg_serial_out(lnk_i.pll_cfg_serial_out),
      .pll_cfg_shift_en(lnk_i.pll_cfg_shift_en),
      .pll_cfg_update(lnk_i.pll_cfg_update),
      .pll_cfg_clk(lnk_i.pll_cfg_clk), .pll_mode(lnk_i.pll_mode));
   // System clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Hang guard, well above the roughly 3600 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] g, e, input string what);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   // One-bit path answers the capture bit, then the data one bit late
   function automatic logic [26:0] one_bit_exp(input logic [26:0] w);
      one_bit_exp = {w[25:0], 1'b0};
   endfunction
   // One test clock period; tdo read late so it has settled
   task automatic step(input logic m, d, output logic o);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (4) @(negedge clk);
      o = tdo;
   endtask
   // Walk the TAP with a tms pattern, LSB first
   task automatic walk(input logic [7:0] pat, input int n);
      logic o;
      for (int i = 0; i < n; i++) step(pat[i], 1'b0, o);
   endtask
   task automatic load_ir(input logic [7:0] op);
      logic o;
      walk(8'h03, 4);
      for (int i = 0; i < 8; i++) step(i == 7, op[i], o);
      walk(8'h01, 2);
      check(lnk_i.instr_reg_bus, op, "instruction bus");
      check(load_selected, op == OPC_LOAD_CFG, "load decode");
   endtask
   // Idle to Shift-DR, n bits LSB first, through Update-DR to Idle
   task automatic shift_dr(input logic [26:0] din, input int n,
                           output logic [26:0] dout);
      logic o;
      dout = '0;
      walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
         check(tdo_oe, 1'b1, "tdo not driven in Shift-DR");
         check(lnk_i.dr_shift_strobe, i != n - 1, "shift strobe");
      end
      // Update-DR step checked on its own, then back to Idle
      step(1'b1, 1'b0, o);
      check(lnk_i.dr_update_strobe, 1'b1, "update strobe");
      check(tdo_oe, 1'b0, "tdo driven outside shift");
      step(1'b0, 1'b0, o);
   endtask
   // Main sequence
   initial begin
      logic [7:0] ops[6];
      int unsigned seed_v;
      rst = 1'b1;
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      seed_v = $urandom(32'h9CC67903);
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (20) @(negedge clk);
      check(lnk_i.tap_reset_n, 1'b0, "TAP reset not held");
      check(pll_ctrl_bits, PLL_STATIC_CFG, "static config");
      check(OPC_LOAD_CFG inside {[8'h10:8'h7F]}, 1'b1, "load range");
      walk(8'h1F, 6);
      check(lnk_i.tap_reset_n, 1'b1, "TAP reset outside reset");
      sr_exp = '0;
      latch_exp = '0;
      // Two loads: each reads back the previous word
      load_ir(OPC_LOAD_CFG);
      repeat (2) begin
         word = 27'($urandom());
         shift_dr(word, CFG_W, got);
         check(got, sr_exp, "config readback");
         sr_exp = word;
         latch_exp = word;
         check(pll_ctrl_bits, PLL_STATIC_CFG, "static while mode low");
      end
      // Mode on, then the captured mode reads back
      load_ir(OPC_DYNAMIC);
      shift_dr(27'h1, 1, got);
      check(mode_status, 1'b1, "mode set");
      check(pll_ctrl_bits, latch_exp, "dynamic config");
      shift_dr(27'h1, 1, got);
      check(got, 27'h1, "mode capture");
      // Other codes: one-bit path with capture 0, PLL untouched
      ops = '{8'h10, 8'h7F, 8'h00, 8'hFF, 8'h22, 8'h80};
      ops[4] = 8'h22 + 8'($urandom % 8'h5E);
      ops[5] = 8'h80 + 8'($urandom % 8'h80);
      foreach (ops[k]) begin
         load_ir(ops[k]);
         word = 27'($urandom());
         shift_dr(word, CFG_W, got);
         check(got, one_bit_exp(word), "one-bit path");
         check(pll_ctrl_bits, latch_exp, "PLL untouched");
      end
      load_ir(OPC_LOAD_CFG);
      word = 27'($urandom());
      shift_dr(word, CFG_W, got);
      check(got, sr_exp, "shift reg kept");
      check(pll_ctrl_bits, word, "new config");
      // TAP reset clears the mode, static config returns
      walk(8'h1F, 6);
      check(mode_status, 1'b0, "mode cleared");
      check(pll_ctrl_bits, PLL_STATIC_CFG, "static again");
      // System reset mid-run holds the TAP again
      // Test clock low at release, else the synchroniser sees a rise
      rst = 1'b1;
      tck = 1'b0;
      tms = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (20) @(negedge clk);
      check(lnk_i.tap_reset_n, 1'b0, "TAP reset after rst");
      tally_and_finish();
   end
endmodule
